// File: rtl/asc_top.sv
// asynchronous serial channel with apb register slave
//
// The implementer's own choices: register access over APB and the address map.
`include "asc_regs.svh"
module asc_top import asc_pkg::*; #(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  input wire logic ext_clock_pin,
  output logic serial_out_pin,
  output logic serial_out_pin_oe_n,
  output logic tx_irq,
  output logic rx_irq
);
  logic [7:0] mode_control_reg_q;
  logic [7:0] rate_divisor_reg_q;
  logic [8:0] tx_buffer_reg_q;
  logic [7:0] control_zero_reg_q;
  logic [7:0] control_one_reg_q;
  logic [8:0] rx_data_q;
  logic tx_holding_vacant_q;
  logic shifter_empty_flag_q;
  logic rx_word_waiting_q;
  logic overrun_fault_q;
  logic framing_fault_q;
  logic parity_fault_q;
  logic [2:0] mode_select_field;
  logic uart_on;
  logic tx_permit;
  logic rx_permit;
  logic acc;
  logic wr;
  logic rd_rxbuf;
  logic mapped;
  logic [31:0] rdata;
  logic [4:0] presc_q;
  logic ext_q;
  logic src_en;
  logic tick;
  asc_frame_s cfg;
  asc_tx_e tx_st_q;
  logic [12:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [3:0] tx_ph_q;
  logic tx_load;
  logic tx_end;
  logic [12:0] tx_vec;
  logic [8:0] tx_dm;
  logic [7:0] tx_rev;
  logic rx_done;
  logic rx_ovr;
  logic [8:0] rx_data;
  logic rx_fer;
  logic rx_per;

  assign mode_select_field = mode_control_reg_q[2:0];
  assign uart_on = mode_select_field == `ASC_SMD_A7 || mode_select_field == `ASC_SMD_A8
    || mode_select_field == `ASC_SMD_A9;
  assign tx_permit = control_one_reg_q[`ASC_C1_TE];
  assign rx_permit = control_one_reg_q[`ASC_C1_RE];

  // frame shape from the mode register, bit order from control zero
  always_comb begin
    cfg.nbits = 4'h8;
    if (mode_select_field == `ASC_SMD_A7) begin
      cfg.nbits = 4'h7;
    end else if (mode_select_field == `ASC_SMD_A9) begin
      cfg.nbits = 4'h9;
    end
    cfg.par_on = mode_control_reg_q[`ASC_MR_PARITY_ON];
    cfg.par_even = mode_control_reg_q[`ASC_MR_PRY];
    cfg.two_stop = mode_control_reg_q[`ASC_MR_STOP_LENGTH_SELECT];
    // order select honoured only for 8-bit characters
    cfg.msb_first = control_zero_reg_q[`ASC_C0_BIT_ORDER_SELECT] && mode_select_field == `ASC_SMD_A8;
  end

  // apb: one wait state so read data comes from a flop
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd_rxbuf = acc && !pwrite && paddr[7:0] == `ASC_OFF_RXBUF;

  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr[7:0])
      `ASC_OFF_MODE: rdata[7:0] = mode_control_reg_q;
      `ASC_OFF_RATE: rdata[7:0] = rate_divisor_reg_q;
      `ASC_OFF_TXBUF: rdata[8:0] = tx_buffer_reg_q;
      `ASC_OFF_CTL0: begin
        rdata[7:0] = control_zero_reg_q;
        rdata[`ASC_C0_SHIFTER_EMPTY_FLAG] = shifter_empty_flag_q;
      end
      `ASC_OFF_CTL1: begin
        rdata[7:0] = control_one_reg_q;
        rdata[`ASC_C1_TI] = tx_holding_vacant_q;
        rdata[`ASC_C1_RI] = rx_word_waiting_q;
      end
      `ASC_OFF_RXBUF: begin
        rdata[8:0] = rx_data_q;
        rdata[`ASC_RB_OER] = overrun_fault_q;
        rdata[`ASC_RB_FER] = framing_fault_q;
        rdata[`ASC_RB_PER] = parity_fault_q;
        rdata[`ASC_RB_SUM] = overrun_fault_q | framing_fault_q | parity_fault_q;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata;
        pslverr <= !mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_control_reg_q <= `ASC_MR_RST;
      rate_divisor_reg_q <= 8'h00;
      control_zero_reg_q <= `ASC_C0_RST;
      control_one_reg_q <= `ASC_C1_RST;
    end else if (wr && pstrb[0]) begin
      case (paddr[7:0])
        `ASC_OFF_MODE: mode_control_reg_q <= pwdata[7:0];
        `ASC_OFF_RATE: rate_divisor_reg_q <= pwdata[7:0];
        `ASC_OFF_CTL0: control_zero_reg_q <= pwdata[7:0];
        `ASC_OFF_CTL1: control_one_reg_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // upper lane takes b8, the lower lane completes the character
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_reg_q <= 9'h000;
      tx_holding_vacant_q <= 1'b1;
    end else begin
      if (wr && paddr[7:0] == `ASC_OFF_TXBUF && pstrb[1]) begin
        tx_buffer_reg_q[8] <= pwdata[8];
      end
      if (wr && paddr[7:0] == `ASC_OFF_TXBUF && pstrb[0]) begin
        tx_buffer_reg_q[7:0] <= pwdata[7:0];
        tx_holding_vacant_q <= 1'b0;
      end else if (tx_load) begin
        tx_holding_vacant_q <= 1'b1;
      end
    end
  end

  // count source: undivided, /8, /32 or external pin edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 5'h00;
      ext_q <= 1'b0;
    end else begin
      presc_q <= presc_q + 5'h01;
      ext_q <= ext_clock_pin;
    end
  end

  always_comb begin
    case (control_zero_reg_q[1:0])
      2'h0: src_en = 1'b1;
      2'h1: src_en = presc_q[2:0] == 3'h0;
      2'h2: src_en = presc_q == 5'h00;
      default: src_en = 1'b0;
    endcase
    if (mode_control_reg_q[`ASC_MR_CLOCK_SOURCE_EXTERNAL_SELECT]) begin
      src_en = ext_clock_pin && !ext_q;
    end
  end

  asc_tick #(.DW(8)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!uart_on),
    .src_en(src_en),
    .divisor(rate_divisor_reg_q),
    .tick(tick)
  );

  // transmit frame image, start bit in bit 0, idle ones above
  for (genvar i = 0; i < 9; i++) begin : g_tx
    assign tx_dm[i] = tx_buffer_reg_q[i] & (4'(i) < cfg.nbits);
    if (i < 8) begin : g_rev
      assign tx_rev[i] = tx_buffer_reg_q[7-i];
    end
  end

  always_comb begin
    tx_vec = 13'h1FFF;
    tx_vec[0] = 1'b0;
    tx_vec[9:1] = cfg.msb_first ? {1'b1, tx_rev} : (tx_dm | ~(9'h1FF >> (4'h9 - cfg.nbits)));
    if (cfg.par_on) begin
      tx_vec[cfg.nbits + 4'h1] = (^tx_dm) ~^ cfg.par_even;
    end
  end

  assign tx_load = tx_st_q == TX_IDLE && uart_on && tx_permit && !tx_holding_vacant_q;
  assign tx_end = tx_st_q == TX_SHIFT && tick && tx_ph_q == `ASC_OVS_LAST && tx_left_q == 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 13'h1FFF;
      tx_left_q <= 4'h0;
      tx_ph_q <= 4'h0;
      shifter_empty_flag_q <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_load) begin
            tx_st_q <= TX_SHIFT;
            tx_sh_q <= tx_vec;
            tx_left_q <= cfg.nbits + {3'h0, cfg.par_on} + {3'h0, cfg.two_stop} + 4'h1;
            tx_ph_q <= 4'h0;
            shifter_empty_flag_q <= 1'b0;
          end
        end
        TX_SHIFT: begin
          if (!uart_on) begin
            tx_st_q <= TX_IDLE;
            tx_sh_q <= 13'h1FFF;
            shifter_empty_flag_q <= 1'b1;
          end else if (tick) begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == `ASC_OVS_LAST) begin
              tx_sh_q <= {1'b1, tx_sh_q[12:1]};
              tx_left_q <= tx_left_q - 4'h1;
              if (tx_left_q == 4'h0) begin
                tx_st_q <= TX_IDLE;
                shifter_empty_flag_q <= 1'b1;
              end
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // open-drain drives only zeros, so a one releases the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin <= 1'b1;
      serial_out_pin_oe_n <= 1'b1;
    end else begin
      serial_out_pin <= tx_sh_q[0];
      if (!uart_on) begin
        serial_out_pin_oe_n <= 1'b1;
      end else if (control_zero_reg_q[`ASC_C0_NCH]) begin
        serial_out_pin_oe_n <= tx_sh_q[0];
      end else begin
        serial_out_pin_oe_n <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq <= 1'b0;
    end else if (control_one_reg_q[`ASC_C1_IRS]) begin
      tx_irq <= tx_end;
    end else begin
      tx_irq <= tx_load;
    end
  end

  asc_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .enable(uart_on && rx_permit),
    .tick(tick),
    .rxd(serial_in_pin),
    .cfg(cfg),
    .done(rx_done),
    .ovr_chk(rx_ovr),
    .data(rx_data),
    .framing_fault(rx_fer),
    .parity_fault(rx_per)
  );

  // receive buffer and faults; a new event beats a read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_q <= 9'h000;
      rx_word_waiting_q <= 1'b0;
      overrun_fault_q <= 1'b0;
      framing_fault_q <= 1'b0;
      parity_fault_q <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= rx_done;
      if (rx_done) begin
        rx_data_q <= rx_data;
        rx_word_waiting_q <= 1'b1;
        framing_fault_q <= rx_fer;
        parity_fault_q <= rx_per;
      end else if (rd_rxbuf) begin
        rx_word_waiting_q <= 1'b0;
        framing_fault_q <= 1'b0;
        parity_fault_q <= 1'b0;
      end
      if (rx_ovr && rx_word_waiting_q && !rd_rxbuf) begin
        overrun_fault_q <= 1'b1;
      end
      if (!uart_on || !rx_permit) begin
        overrun_fault_q <= 1'b0;
        framing_fault_q <= 1'b0;
        parity_fault_q <= 1'b0;
      end
    end
  end
endmodule : asc_top

// File: rtl/asc_regs.svh
// register offsets, field positions, reset values and counts of the serial channel
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_OFF_MODE 8'h00
`define ASC_OFF_RATE 8'h04
`define ASC_OFF_TXBUF 8'h08
`define ASC_OFF_CTL0 8'h0C
`define ASC_OFF_CTL1 8'h10
`define ASC_OFF_RXBUF 8'h14
`define ASC_MR_RST 8'h00
`define ASC_C0_RST 8'h08
`define ASC_C1_RST 8'h02
`define ASC_MR_CLOCK_SOURCE_EXTERNAL_SELECT 3
`define ASC_MR_STOP_LENGTH_SELECT 4
`define ASC_MR_PRY 5
`define ASC_MR_PARITY_ON 6
`define ASC_C0_SHIFTER_EMPTY_FLAG 3
`define ASC_C0_NCH 5
`define ASC_C0_CLOCK_EDGE_POLARITY 6
`define ASC_C0_BIT_ORDER_SELECT 7
`define ASC_C1_TE 0
`define ASC_C1_TI 1
`define ASC_C1_RE 2
`define ASC_C1_RI 3
`define ASC_C1_IRS 4
`define ASC_RB_OER 12
`define ASC_RB_FER 13
`define ASC_RB_PER 14
`define ASC_RB_SUM 15
`define ASC_SMD_OFF 3'h0
`define ASC_SMD_A7 3'h4
`define ASC_SMD_A8 3'h5
`define ASC_SMD_A9 3'h6
`define ASC_OVS_LAST 4'hF
`define ASC_MID_TICK 4'h7
`endif

// File: rtl/asc_pkg.sv
// types shared by the serial channel modules
package asc_pkg;
  typedef struct packed {
    logic [3:0] nbits;
    logic par_on;
    logic par_even;
    logic two_stop;
    logic msb_first;
  } asc_frame_s;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } asc_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } asc_rx_e;
endpackage : asc_pkg

// File: rtl/asc_tick.sv
// reloadable divisor giving the sixteen-times bit clock
module asc_tick import asc_pkg::*; #(
  parameter int DW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic src_en,
  input wire logic [DW-1:0] divisor,
  output logic tick
);
  logic [DW-1:0] cnt_q;

  // divide by divisor plus one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (clear) begin
      cnt_q <= divisor;
      tick <= 1'b0;
    end else if (src_en && cnt_q == '0) begin
      cnt_q <= divisor;
      tick <= 1'b1;
    end else begin
      if (src_en) begin
        cnt_q <= cnt_q - DW'(1);
      end
      tick <= 1'b0;
    end
  end
endmodule : asc_tick

// File: rtl/asc_rx.sv
// receive shifter: start qualify, mid-bit sampling, frame checks
module asc_rx import asc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic tick,
  input wire logic rxd,
  input wire asc_frame_s cfg,
  output logic done,
  output logic ovr_chk,
  output logic [8:0] data,
  output logic framing_fault,
  output logic parity_fault
);
  asc_rx_e st_q;
  logic [3:0] ph_q;
  logic [3:0] idx_q;
  logic [11:0] frame_q;
  logic [3:0] last;
  logic [8:0] dmask;
  logic [7:0] rev;
  logic pbit;
  logic s1;
  logic s2;

  assign last = cfg.nbits + {3'h0, cfg.par_on} + {3'h0, cfg.two_stop};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= RX_IDLE;
      ph_q <= 4'h0;
      idx_q <= 4'h0;
      frame_q <= 12'h000;
      done <= 1'b0;
      ovr_chk <= 1'b0;
    end else begin
      done <= 1'b0;
      ovr_chk <= 1'b0;
      if (!enable) begin
        st_q <= RX_IDLE;
      end else if (tick) begin
        case (st_q)
          RX_IDLE: begin
            if (!rxd) begin
              st_q <= RX_START;
              ph_q <= 4'h0;
            end
          end
          RX_START: begin
            ph_q <= ph_q + 4'h1;
            if (ph_q == `ASC_MID_TICK) begin
              st_q <= rxd ? RX_IDLE : RX_BITS;
              ph_q <= 4'h0;
              idx_q <= 4'h0;
            end
          end
          RX_BITS: begin
            ph_q <= ph_q + 4'h1;
            if (ph_q == `ASC_OVS_LAST) begin
              frame_q[idx_q] <= rxd;
              idx_q <= idx_q + 4'h1;
              if (idx_q == last - 4'h1) begin
                ovr_chk <= 1'b1;
              end
              if (idx_q == last) begin
                done <= 1'b1;
                st_q <= RX_IDLE;
              end
            end
          end
          default: st_q <= RX_IDLE;
        endcase
      end
    end
  end

  for (genvar i = 0; i < 9; i++) begin : g_bit
    assign dmask[i] = frame_q[i] & (4'(i) < cfg.nbits);
    if (i < 8) begin : g_rev
      assign rev[i] = frame_q[7-i];
    end
  end

  assign pbit = frame_q[cfg.nbits];
  assign s1 = frame_q[cfg.nbits + {3'h0, cfg.par_on}];
  assign s2 = frame_q[cfg.nbits + {3'h0, cfg.par_on} + 4'h1];
  assign data = cfg.msb_first ? {1'b0, rev} : dmask;
  assign framing_fault = !s1 || (cfg.two_stop && !s2);
  assign parity_fault = cfg.par_on && ((^dmask ^ pbit) == cfg.par_even);
endmodule : asc_rx

// File: tb/asc_checker.sv
// port-level assertions for the serial channel
`include "asc_regs.svh"
module asc_checker #(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_out_pin,
  input wire logic serial_out_pin_oe_n,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the open-drain choice, seen only through bus writes
  logic od_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) od_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr[7:0] == `ASC_OFF_CTL0 && pstrb[0])
      od_q <= pwdata[`ASC_C0_NCH];
  end
  property p_one_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer not after one wait state");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
  property p_err_resp;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_resp: assert property (p_err_resp) else $error("error response malformed");
  property p_txirq_pulse;
    tx_irq |=> !tx_irq;
  endproperty
  a_txirq_pulse: assert property (p_txirq_pulse) else $error("tx irq not a pulse");
  property p_rxirq_pulse;
    rx_irq |=> !rx_irq;
  endproperty
  a_rxirq_pulse: assert property (p_rxirq_pulse) else $error("rx irq not a pulse");
  property p_bit_hold;
    $fell(serial_out_pin) |-> !serial_out_pin [*8];
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("low bit shorter than half bit");
  property p_od_drive;
    // the pin follows a control write one cycle late
    od_q && $past(od_q) && !serial_out_pin_oe_n |-> !serial_out_pin;
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("open drain drives a one");
endmodule : asc_checker

// File: tb/asc_remote.sv
// far-end serial transceiver model, bit period given per call
module asc_remote (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_out = 1'b1;
  // start bit then frame bits lsb first, line back high after
  task automatic send(input logic [11:0] f, input int n, input int parity_fault);
    line_out <= 1'b0;
    repeat (parity_fault) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (parity_fault) @(posedge pclk);
    end
    line_out <= 1'b1;
    // one idle cycle so a following frame never rewrites the line in this step
    @(posedge pclk);
  endtask : send
  // samples each bit at its centre, counted from the start edge
  task automatic grab(output logic [11:0] f, input int n, input int parity_fault);
    f = 12'hFFF;
    while (line_in !== 1'b0) @(posedge pclk);
    repeat (parity_fault / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      repeat (parity_fault) @(posedge pclk);
      f[i] = line_in;
    end
  endtask : grab
endmodule : asc_remote

// File: tb/async_serial_channel_test.sv
// self-checking bench for the serial channel
`include "asc_regs.svh"
module async_serial_channel_test import asc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] ec = 2'h0;
  logic pready, pslverr, txd, txd_oe_n, txd_wire, rxd, tx_irq, rx_irq;
  int num_errors = 0, checks_done = 0, txi_n = 0, rxi_n = 0, lows = 0;
  asc_frame_s cfgs [3] = '{'{4'h7, 1, 0, 0, 0}, '{4'h8, 1, 1, 1, 1}, '{4'h9, 0, 0, 0, 0}};
  logic [8:0] dat [3] = '{9'h05A, 9'h0C3, 9'h1A5};
  always #10 pclk = ~pclk;
  // external count source at a quarter of pclk
  always @(posedge pclk) ec <= ec + 2'h1;
  // pull-up on the line while the output is released
  assign txd_wire = txd_oe_n ? 1'b1 : txd;
  always @(posedge pclk) begin
    txi_n += int'(tx_irq === 1'b1);
    rxi_n += int'(rx_irq === 1'b1);
    lows += int'(txd_wire !== 1'b1);
  end
  asc_top #(.AW(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(rxd), .ext_clock_pin(ec[1]),
    .serial_out_pin(txd), .serial_out_pin_oe_n(txd_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq));
  asc_remote remote (.pclk(pclk), .line_in(txd_wire), .line_out(rxd));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hF, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, 4'hF, r, e);
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic wait_irq(input bit rx, input int tgt);
    for (int k = 0; k < 3000 && (rx ? rxi_n : txi_n) < tgt; k++) @(posedge pclk);
    chk(rx ? "rx irq count" : "tx irq count", 32'(tgt), 32'(rx ? rxi_n : txi_n));
  endtask : wait_irq
  // expected frame bits after the start bit, idle ones beyond the stops
  function automatic logic [11:0] frame(input logic [8:0] d, input asc_frame_s c,
                                        input int bad);
    logic [11:0] f;
    logic x;
    int nb;
    f = 12'hFFF;
    x = 1'b0;
    nb = int'(c.nbits);
    for (int k = 0; k < nb; k++) begin
      f[k] = c.msb_first ? d[nb - 1 - k] : d[k];
      x ^= d[k];
    end
    if (c.par_on) f[nb] = x ^ ~c.par_even ^ (bad == 1);
    if (bad == 2) f[nb + int'(c.par_on)] = 1'b0;
    return f;
  endfunction : frame
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    $display("[FAIL] watchdog expected end seen timeout");
    conclude();
  end
  initial begin
    logic [31:0] r;
    logic [11:0] f, g;
    logic e;
    asc_frame_s c;
    int nb, tgt;
    // bit periods in pclk cycles: /1 n=1, external n=0, /8 n=0, /32 n=0
    int pers [4] = '{32, 64, 128, 512};
    logic [7:0] offs [5] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14};
    logic [31:0] rst [5] = '{32'h0, 32'h0, 32'h8, 32'h2, 32'h0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) begin
      rd(offs[i], r);
      chk("reset value", rst[i], r);
    end
    apb(1'b0, 8'h18, 32'h0, 4'hF, r, e);
    chk("unmapped error", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      c = cfgs[i];
      nb = int'(c.nbits);
      wr(`ASC_OFF_CTL1, 32'h0);
      wr(`ASC_OFF_MODE, 32'h0);
      wr(`ASC_OFF_MODE, {25'h0, c.par_on, c.par_even, c.two_stop, 1'b0, 3'(nb - 3)});
      wr(`ASC_OFF_CTL0, {24'h0, c.msb_first, 1'b0, i == 0, 5'h0});
      wr(`ASC_OFF_CTL1, 32'h5);
      f = frame(dat[i], c, 0);
      nb = nb + int'(c.par_on) + 1 + int'(c.two_stop);
      tgt = txi_n + 1;
      fork
        remote.grab(g, nb, 16);
        begin
          if (c.nbits == 4'h9) apb(1'b1, `ASC_OFF_TXBUF, {23'h0, dat[i]}, 4'h2, r, e);
          apb(1'b1, `ASC_OFF_TXBUF, {23'h0, dat[i]}, 4'h1, r, e);
        end
      join
      chk("tx frame", f, g);
      wait_irq(1'b0, tgt);
      tgt = rxi_n + 1;
      remote.send(f, nb, 16);
      wait_irq(1'b1, tgt);
      rd(`ASC_OFF_RXBUF, r);
      chk("rx word", {23'h0, dat[i]}, r);
    end
    $display("format test done");
    c = '{4'h8, 1, 0, 0, 0};
    wr(`ASC_OFF_CTL1, 32'h0);
    wr(`ASC_OFF_MODE, 32'h0);
    wr(`ASC_OFF_MODE, 32'h45);
    wr(`ASC_OFF_CTL0, 32'h0);
    wr(`ASC_OFF_CTL1, 32'h4);
    for (int b = 1; b < 3; b++) begin
      tgt = rxi_n + 1;
      remote.send(frame(9'h03C, c, b), 10, 16);
      wait_irq(1'b1, tgt);
      rd(`ASC_OFF_RXBUF, r);
      chk("fault flags", b == 1 ? 32'hC : 32'hA, 32'(r[15:12]));
    end
    tgt = rxi_n + 2;
    repeat (2) remote.send(frame(9'h03C, c, 0), 10, 16);
    wait_irq(1'b1, tgt);
    rd(`ASC_OFF_RXBUF, r);
    chk("overrun", 32'h9, 32'(r[15:12]));
    rd(`ASC_OFF_RXBUF, r);
    chk("overrun kept", 32'h9, 32'(r[15:12]));
    rd(`ASC_OFF_CTL1, r);
    chk("control one", 32'h6, r);
    wr(`ASC_OFF_CTL1, 32'h0);
    rd(`ASC_OFF_RXBUF, r);
    chk("faults off", 32'h0, 32'(r[15:12]));
    $display("fault test done");
    c = '{4'h8, 0, 0, 0, 0};
    for (int j = 0; j < 4; j++) begin
      wr(`ASC_OFF_MODE, 32'h0);
      wr(`ASC_OFF_MODE, j == 1 ? 32'hD : 32'h5);
      wr(`ASC_OFF_CTL0, j > 1 ? 32'(j - 1) : 32'h0);
      wr(`ASC_OFF_RATE, j == 0 ? 32'h1 : 32'h0);
      apb(1'b1, `ASC_OFF_TXBUF, 32'h96, 4'h1, r, e);
      lows = 0;
      repeat (200) @(posedge pclk);
      chk("held idle", 32'h0, 32'(lows));
      tgt = txi_n + 1;
      fork
        remote.grab(g, 10, pers[j]);
        wr(`ASC_OFF_CTL1, 32'h11);
      join
      chk("rate frame", frame(9'h096, c, 0), g);
      wait_irq(1'b0, tgt);
      wr(`ASC_OFF_CTL1, 32'h0);
    end
    $display("rate test done");
    conclude();
  end
endmodule : async_serial_channel_test
bind asc_top asc_checker #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
  .serial_out_pin_oe_n(serial_out_pin_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq));
